// ---- design/prom_host.sv ----
// host-side sequencer driving the memory's pins for read, identifier readout and programming
`timescale 1ns/1ps
`default_nettype none
module prom_host #(
   parameter int unsigned ADDR_W = 16,
   parameter int unsigned DATA_W = 16,
   parameter int unsigned N_DEV = 1,
   parameter int unsigned DEV_W = 1,
   parameter int unsigned PULSE_CYCLES = prom_host_pkg::PULSE_CYC,
   parameter int unsigned MAX_PULSES = prom_host_pkg::MAX_PULSES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // command side
   input wire logic i_cmd_valid,
   input wire logic [1:0] i_cmd,
   input wire logic [DEV_W-1:0] i_dev_sel,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_deep_standby,
   output logic o_busy,
   output logic o_done,
   output logic o_fail,
   output logic o_parity_ok,
   output logic [DATA_W-1:0] o_rdata,
   // memory pins
   output logic [N_DEV-1:0] o_ce_n,
   output logic o_deep_standby,
   output logic o_oe_n,
   output logic o_write_pulse_n,
   output logic o_program_supply_level,
   output logic o_id_entry_addr_line,
   output logic [ADDR_W-1:0] o_addr,
   input wire logic [DATA_W-1:0] i_dq,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe
);
   localparam logic [prom_host_pkg::TMR_W-1:0] LD_PULSE = prom_host_pkg::TMR_W'(PULSE_CYCLES - 1); // zero counts too
   localparam logic [prom_host_pkg::TMR_W-1:0] LD_ACCESS =
      prom_host_pkg::TMR_W'(prom_host_pkg::ACCESS_CYC + prom_host_pkg::SYNC_STAGES);
   localparam logic [prom_host_pkg::TMR_W-1:0] LD_SETTLE = prom_host_pkg::TMR_W'(prom_host_pkg::SETTLE_CYC);
   localparam logic [prom_host_pkg::TMR_W-1:0] LD_GAP = prom_host_pkg::TMR_W'(prom_host_pkg::GAP_CYC);
   localparam logic [7:0] PULSE_LIMIT = 8'(MAX_PULSES);

   // odd parity over an identifier byte, top bit included
   function automatic logic odd_parity(input logic [prom_host_pkg::ID_BYTE_W-1:0] b);
      odd_parity = ^b;
   endfunction : odd_parity

   wait_timer_if tif ();

   wait_timer u_timer (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .tmr(tif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // data pins come from another timing domain: two stages before use
   logic [DATA_W-1:0] dq_meta;
   logic [DATA_W-1:0] dq_sync;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         dq_meta <= '0;
         dq_sync <= '0;
      end else if (i_ce) begin
         dq_meta <= i_dq;
         dq_sync <= dq_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state
   prom_host_pkg::state_t state, next_state;
   prom_host_pkg::cmd_t op, next_op;
   logic [DEV_W-1:0] dev, next_dev;
   logic [7:0] pulses, next_pulses;
   logic [DATA_W-1:0] wdata, next_wdata;
   logic ce_act, next_ce_act;
   logic busy, next_busy;
   logic done, next_done;
   logic fail, next_fail;
   logic par_ok, next_par_ok;
   logic [DATA_W-1:0] rdata, next_rdata;
   logic oe_n, next_oe_n;
   logic wp_n, next_wp_n;
   logic vpp, next_vpp;
   logic a9hv, next_a9hv;
   logic deep, next_deep;
   logic [ADDR_W-1:0] addr, next_addr;
   logic dq_oe, next_dq_oe;
   logic t_start;
   logic [prom_host_pkg::TMR_W-1:0] t_load;

   // next values of the whole sequencer and of the pins it owns
   always_comb begin
      next_state = state;
      next_op = op;
      next_dev = dev;
      next_pulses = pulses;
      next_wdata = wdata;
      next_ce_act = ce_act;
      next_busy = busy;
      next_done = 1'b0;
      next_fail = fail;
      next_par_ok = par_ok;
      next_rdata = rdata;
      next_oe_n = oe_n;
      next_wp_n = wp_n;
      next_vpp = vpp;
      next_a9hv = a9hv;
      next_deep = deep;
      next_addr = addr;
      next_dq_oe = dq_oe;
      t_start = 1'b0;
      t_load = LD_GAP;
      case (state)
         prom_host_pkg::ST_IDLE: begin
            next_deep = i_deep_standby;
            if (i_cmd_valid && (prom_host_pkg::cmd_t'(i_cmd) != prom_host_pkg::CMD_NOP)) begin
               next_op = prom_host_pkg::cmd_t'(i_cmd);
               next_dev = i_dev_sel;
               next_wdata = i_wdata;
               next_pulses = '0;
               next_busy = 1'b1;
               next_fail = 1'b0;
               next_deep = 1'b0;
               next_wp_n = 1'b1;
               t_start = 1'b1;
               if (prom_host_pkg::cmd_t'(i_cmd) == prom_host_pkg::CMD_PROG) begin
                  // raise the supply with chip-enable still high: inhibited meanwhile
                  next_addr = i_addr;
                  next_vpp = 1'b1;
                  t_load = LD_SETTLE;
                  next_state = prom_host_pkg::ST_SETTLE;
               end else if (prom_host_pkg::cmd_t'(i_cmd) == prom_host_pkg::CMD_ID) begin
                  next_addr = '0;
                  next_addr[0] = i_addr[0];
                  next_a9hv = 1'b1;
                  t_load = LD_SETTLE;
                  next_state = prom_host_pkg::ST_SETTLE;
               end else begin
                  next_addr = i_addr;
                  next_ce_act = 1'b1;
                  next_oe_n = 1'b0;
                  t_load = LD_ACCESS;
                  next_state = prom_host_pkg::ST_ACCESS;
               end
            end
         end
         prom_host_pkg::ST_SETTLE: begin
            if (tif.done) begin
               // verify or identifier read: both enables low, write pulse high
               next_ce_act = 1'b1;
               next_oe_n = 1'b0;
               next_wp_n = 1'b1;
               t_start = 1'b1;
               t_load = LD_ACCESS;
               next_state = prom_host_pkg::ST_ACCESS;
            end
         end
         prom_host_pkg::ST_ACCESS: begin
            if (tif.done) begin
               next_rdata = dq_sync;
               next_par_ok = odd_parity(dq_sync[prom_host_pkg::ID_BYTE_W-1:0]);
               next_oe_n = 1'b1;
               next_ce_act = 1'b0;
               t_start = 1'b1;
               if (op == prom_host_pkg::CMD_PROG && dq_sync != wdata) begin
                  if ((~dq_sync & wdata) != '0 || pulses == PULSE_LIMIT) begin
                     // a zero cannot return to one; or the pulse budget is spent
                     next_fail = 1'b1;
                     next_state = prom_host_pkg::ST_RECOVER;
                  end else begin
                     next_state = prom_host_pkg::ST_ARM;
                  end
               end else begin
                  next_state = prom_host_pkg::ST_RECOVER;
               end
            end
         end
         prom_host_pkg::ST_ARM: begin
            // outputs floated one gap earlier, so the bus is free to drive
            if (tif.done) begin
               next_dq_oe = 1'b1;
               next_wp_n = 1'b0;
               t_start = 1'b1;
               next_state = prom_host_pkg::ST_LOAD;
            end
         end
         prom_host_pkg::ST_LOAD: begin
            if (tif.done) begin
               next_ce_act = 1'b1;
               t_start = 1'b1;
               t_load = LD_PULSE;
               next_state = prom_host_pkg::ST_PULSE;
            end
         end
         prom_host_pkg::ST_PULSE: begin
            if (tif.done) begin
               next_ce_act = 1'b0;
               next_pulses = pulses + 8'h01;
               t_start = 1'b1;
               next_state = prom_host_pkg::ST_RECOVER;
            end
         end
         prom_host_pkg::ST_RECOVER: begin
            if (tif.done) begin
               next_dq_oe = 1'b0;
               next_wp_n = 1'b1;
               t_start = 1'b1;
               if (busy && op == prom_host_pkg::CMD_PROG && !fail && pulses != 8'h00 && next_rdata != wdata) begin
                  next_state = prom_host_pkg::ST_SETTLE; // back to verify
               end else if (busy && op == prom_host_pkg::CMD_PROG && pulses != 8'h00 && !fail
                            && rdata != wdata) begin
                  next_state = prom_host_pkg::ST_SETTLE;
               end else begin
                  next_vpp = 1'b0;
                  next_a9hv = 1'b0;
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  next_state = prom_host_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            next_state = prom_host_pkg::ST_IDLE;
         end
      endcase
   end

   assign tif.start = t_start;
   assign tif.load = t_load;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state <= prom_host_pkg::ST_IDLE;
         op <= prom_host_pkg::CMD_NOP;
         dev <= '0;
         pulses <= 8'h00;
         wdata <= '0;
         ce_act <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         par_ok <= 1'b0;
         rdata <= '0;
         oe_n <= 1'b1;
         wp_n <= 1'b1;
         vpp <= 1'b0;
         a9hv <= 1'b0;
         deep <= 1'b0;
         addr <= '0;
         dq_oe <= 1'b0;
      end else if (i_ce) begin
         state <= next_state;
         op <= next_op;
         dev <= next_dev;
         pulses <= next_pulses;
         wdata <= next_wdata;
         ce_act <= next_ce_act;
         busy <= next_busy;
         done <= next_done;
         fail <= next_fail;
         par_ok <= next_par_ok;
         rdata <= next_rdata;
         oe_n <= next_oe_n;
         wp_n <= next_wp_n;
         vpp <= next_vpp;
         a9hv <= next_a9hv;
         deep <= next_deep;
         addr <= next_addr;
         dq_oe <= next_dq_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one chip-enable per device; all other pins are shared
   for (genvar g = 0; g < N_DEV; g++) begin : g_ce
      logic next_ce_n;
      always_comb begin
         next_ce_n = !(next_ce_act && (next_dev == DEV_W'(g)));
      end
      always_ff @(posedge i_ref_clk) begin
         if (!i_rst_n) begin
            o_ce_n[g] <= 1'b1;
         end else if (i_ce) begin
            o_ce_n[g] <= next_ce_n;
         end
      end
   end

   assign o_busy = busy;
   assign o_done = done;
   assign o_fail = fail;
   assign o_parity_ok = par_ok;
   assign o_rdata = rdata;
   assign o_deep_standby = deep;
   assign o_oe_n = oe_n;
   assign o_write_pulse_n = wp_n;
   assign o_program_supply_level = vpp;
   assign o_id_entry_addr_line = a9hv;
   assign o_addr = addr;
   assign o_dq = wdata;
   assign o_dq_oe = dq_oe;
endmodule : prom_host
`default_nettype wire

// ---- design/prom_host_pkg.sv ----
// constants and types for the programmable read-only memory host controller
package prom_host_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // programming pulse width and derived count, rounded up
   localparam int unsigned T_PULSE_NS = 100000;
   localparam int unsigned PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // slowest access grade, rounded up so data is settled when sampled
   localparam int unsigned T_ACCESS_NS = 250;
   localparam int unsigned ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // program supply settling before any strobe
   localparam int unsigned T_SETTLE_NS = 2000;
   localparam int unsigned SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // setup and hold around pulses and bus turnaround
   localparam int unsigned T_GAP_NS = 20;
   localparam int unsigned GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned MAX_PULSES = 25;
   localparam int unsigned TMR_W = 16;
   localparam int unsigned ID_BYTE_W = 8;

   typedef enum logic [1:0] {
      CMD_READ = 2'h0,
      CMD_PROG = 2'h1,
      CMD_ID = 2'h2,
      CMD_NOP = 2'h3
   } cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETTLE = 3'h1,
      ST_ACCESS = 3'h2,
      ST_ARM = 3'h3,
      ST_LOAD = 3'h4,
      ST_PULSE = 3'h5,
      ST_RECOVER = 3'h6
   } state_t;
endpackage : prom_host_pkg

// ---- design/wait_timer_if.sv ----
// carrier between the sequencer and its wait timer
`timescale 1ns/1ps
`default_nettype none
interface wait_timer_if;
   logic start;
   logic [prom_host_pkg::TMR_W-1:0] load;
   logic done;
   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface : wait_timer_if
`default_nettype wire

// ---- design/wait_timer.sv ----
// down-counting wait timer, done while the count stands at zero
`timescale 1ns/1ps
`default_nettype none
module wait_timer (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   wait_timer_if.tmr tmr
);
   logic [prom_host_pkg::TMR_W-1:0] cnt;
   logic [prom_host_pkg::TMR_W-1:0] next_cnt;

   // a start always wins over the running count
   always_comb begin
      next_cnt = cnt;
      if (tmr.start) begin
         next_cnt = tmr.load;
      end else if (cnt != '0) begin
         next_cnt = cnt - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         cnt <= '0;
      end else if (i_ce) begin
         cnt <= next_cnt;
      end
   end

   assign tmr.done = (cnt == '0);
endmodule : wait_timer
`default_nettype wire

// ---- tb/prom_model.sv ----
// behavioural model of one programmable read-only memory seen from its pins
`timescale 1ns/1ps
`default_nettype none
module prom_model #(
   parameter logic [7:0] MAKER_ID = 8'h2A, // arbitrary value, odd parity
   parameter logic [7:0] DEV_ID = 8'h83, // arbitrary value, odd parity
   parameter logic [15:0] STUCK_A = 16'hFFFF
) (
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_write_pulse_n,
   input wire logic i_program_supply_level,
   input wire logic i_id_entry_addr_line,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq,
   output logic o_dq_oe
);
   logic [15:0] mem [0:65535];
   logic [15:0] word;
   logic prog;
   logic en;
   logic en_d;
   ////////////////////////////////////////////////////////////////
   // an erased part reads all ones
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 16'hFFFF;
      end
   end
   // mode decode straight from pin levels
   assign prog = !i_ce_n && !i_write_pulse_n && i_program_supply_level;
   // word taken at the end of the pulse; bits only fall; stuck word never takes
   always @(posedge i_ce_n) begin
      if (!i_write_pulse_n && i_program_supply_level && i_addr != STUCK_A) begin
         mem[i_addr] <= mem[i_addr] & i_dq;
      end
   end
   // identifier only while the other address lines are low
   always_comb begin
      if (!i_id_entry_addr_line) begin
         word = mem[i_addr];
      end else if (i_addr[15:1] == 15'h0) begin
         word = {8'h00, i_addr[0] ? DEV_ID : MAKER_ID};
      end else begin
         word = ~mem[i_addr];
      end
   end
   // slow turn-on, prompt float so a turnaround is never hidden
   assign en = !i_ce_n && !i_oe_n && !prog;
   assign #60 en_d = en;
   assign o_dq_oe = en && en_d;
   assign o_dq = word;
endmodule : prom_model
`default_nettype wire

// ---- tb/prom_host_asserts.sv ----
// pin protocol checks for the memory host sequencer
`timescale 1ns/1ps
`default_nettype none
module prom_host_asserts #(
   parameter int unsigned ADDR_W = 16,
   parameter int unsigned N_DEV = 1,
   parameter int unsigned PULSE_CYCLES = prom_host_pkg::PULSE_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic o_busy,
   input wire logic [N_DEV-1:0] o_ce_n,
   input wire logic o_deep_standby,
   input wire logic o_oe_n,
   input wire logic o_write_pulse_n,
   input wire logic o_program_supply_level,
   input wire logic o_id_entry_addr_line,
   input wire logic [ADDR_W-1:0] o_addr,
   input wire logic o_dq_oe
);
   logic [31:0] pulse_len;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////
   // cycles a chip-enable has been low under a write pulse
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || &o_ce_n) begin
         pulse_len <= 32'h0;
      end else if (i_ce && !o_write_pulse_n) begin
         pulse_len <= pulse_len + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////
   a_pulse_setup: assert property (!o_write_pulse_n && !(&o_ce_n) |->
      o_program_supply_level && o_dq_oe && o_oe_n)
      else $error("pulse without supply or data");
   a_one_select: assert property ($onehot0(~o_ce_n))
      else $error("more than one device selected");
   a_id_addr_low: assert property (o_id_entry_addr_line |-> o_addr[ADDR_W-1:1] == '0)
      else $error("address lines not low in identifier mode");
   a_id_no_pulse: assert property (o_id_entry_addr_line && !o_oe_n |-> o_write_pulse_n && !(&o_ce_n))
      else $error("identifier read with bad enables");
   a_no_clash: assert property (o_dq_oe |-> o_oe_n)
      else $error("host drives data while outputs enabled");
   a_pulse_len: assert property ($rose(&o_ce_n) && !o_write_pulse_n |-> pulse_len == PULSE_CYCLES)
      else $error("program pulse has wrong length");
   a_verify_next: assert property ($rose(o_write_pulse_n) |-> ##[1:400] (!o_oe_n && !(&o_ce_n)))
      else $error("no verify after pulse");
   a_deep_idle: assert property (o_deep_standby |-> &o_ce_n && !o_busy)
      else $error("deep standby while selected");
   a_strobe_sel: assert property (!o_oe_n |-> !(&o_ce_n))
      else $error("read strobe with no device selected");
   cover property ($rose(o_id_entry_addr_line));
   cover property ($fell(o_write_pulse_n));
   cover property ($rose(o_deep_standby));
endmodule : prom_host_asserts
`default_nettype wire

// ---- tb/uv_prom_mode_select_tb.sv ----
// self-checking bench: host sequencer against two memory models
`timescale 1ns/1ps
`default_nettype none
module uv_prom_mode_select_tb;
   localparam int unsigned PULSE = 20;
   localparam int unsigned MAXP = 3;
   logic clk;
   logic rst_n;
   logic ce;
   logic cmd_valid;
   logic deep;
   logic deep_o;
   logic [1:0] cmd;
   logic [0:0] dev;
   logic [15:0] addr, wdata, rdata, dq_in, dq_out, a_pins, m0_q, m1_q;
   logic [15:0] last = 16'h0;
   logic busy, done, fail, par_ok, oe_n, wp_n, vpp, vh, dq_oe, m0_oe, m1_oe;
   logic [1:0] ce_n;
   int errors, n_compared, pulses;
   ////////////////////////////////////////////////////////////////
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   prom_host #(.N_DEV(2), .DEV_W(1), .PULSE_CYCLES(PULSE), .MAX_PULSES(MAXP)) dut_u (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
      .i_dev_sel(dev), .i_addr(addr), .i_wdata(wdata), .i_deep_standby(deep), .o_busy(busy),
      .o_done(done), .o_fail(fail), .o_parity_ok(par_ok), .o_rdata(rdata), .o_ce_n(ce_n),
      .o_deep_standby(deep_o), .o_oe_n(oe_n), .o_write_pulse_n(wp_n), .o_program_supply_level(vpp),
      .o_id_entry_addr_line(vh), .o_addr(a_pins), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(dq_oe));
   prom_model #(.STUCK_A(16'h0040)) m0_u (.i_ce_n(ce_n[0]), .i_oe_n(oe_n), .i_write_pulse_n(wp_n),
      .i_program_supply_level(vpp), .i_id_entry_addr_line(vh), .i_addr(a_pins), .i_dq(dq_in),
      .o_dq(m0_q), .o_dq_oe(m0_oe));
   // every pin shared except chip-enable
   prom_model m1_u (.i_ce_n(ce_n[1]), .i_oe_n(oe_n), .i_write_pulse_n(wp_n),
      .i_program_supply_level(vpp), .i_id_entry_addr_line(vh), .i_addr(a_pins), .i_dq(dq_in),
      .o_dq(m1_q), .o_dq_oe(m1_oe));
   // no pull on the data lines: a floating bus shows the inverse of its last value
   assign dq_in = m0_oe ? m0_q : (m1_oe ? m1_q : (dq_oe ? dq_out : ~last));
   always @(posedge clk) begin
      if (m0_oe | m1_oe | dq_oe) last <= dq_in;
   end
   // program pulses seen by the first device
   always @(posedge ce_n[0]) begin
      if (!wp_n) pulses++;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   // one command, waited for under a bounded count
   task automatic run(input logic [1:0] c, input logic d, input logic [15:0] a, input logic [15:0] w);
      int n;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd = c;
      dev = d;
      addr = a;
      wdata = w;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      chk({15'h0, busy}, 16'h1, "busy after take");
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 20000) begin
         errors++;
         $display("[FAIL] %0t no completion", $time);
         print_verdict();
      end
      chk({15'h0, busy}, 16'h0, "idle at done");
      @(posedge clk);
      #1;
      chk({15'h0, done}, 16'h0, "done lasts one cycle");
   endtask : run
   ////////////////////////////////////////////////////////////////
   task automatic t_program();
      run(prom_host_pkg::CMD_READ, 1'b0, 16'h1234, 16'h0);
      chk(rdata, 16'hFFFF, "erased read");
      chk({15'h0, par_ok}, 16'h0, "erased parity");
      run(prom_host_pkg::CMD_PROG, 1'b0, 16'h0010, 16'hA5C3);
      chk({15'h0, fail}, 16'h0, "program status");
      chk(rdata, 16'hA5C3, "verify word");
      run(prom_host_pkg::CMD_READ, 1'b0, 16'h0010, 16'h0);
      chk(rdata, 16'hA5C3, "read back");
      run(prom_host_pkg::CMD_READ, 1'b1, 16'h0010, 16'h0);
      chk(rdata, 16'hFFFF, "other device untouched");
      run(prom_host_pkg::CMD_PROG, 1'b0, 16'h0010, 16'hFFFF);
      chk({15'h0, fail}, 16'h1, "cannot raise bits");
      $display("test program done");
   endtask : t_program
   task automatic t_stuck();
      pulses = 0;
      run(prom_host_pkg::CMD_PROG, 1'b0, 16'h0040, 16'h0000);
      chk({15'h0, fail}, 16'h1, "stuck word fails");
      chk(pulses[15:0], MAXP[15:0], "pulse limit");
      $display("test stuck done");
   endtask : t_stuck
   // enable low freezes the sequencer; the no-operation code is refused
   task automatic t_freeze();
      ce = 1'b0;
      cmd_valid = 1'b1;
      cmd = prom_host_pkg::CMD_READ;
      dev = 1'b0;
      addr = 16'h0010;
      repeat (4) @(posedge clk);
      #1;
      chk({15'h0, busy}, 16'h0, "frozen while disabled");
      chk({14'h0, ce_n}, 16'h3, "pins frozen");
      ce = 1'b1;
      cmd = prom_host_pkg::CMD_NOP;
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, busy}, 16'h0, "no-operation ignored");
      cmd_valid = 1'b0;
      run(prom_host_pkg::CMD_READ, 1'b0, 16'h0010, 16'h0);
      chk(rdata, 16'hA5C3, "read after freeze");
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_ident();
      run(prom_host_pkg::CMD_ID, 1'b1, 16'hFFFE, 16'h0);
      chk(rdata, 16'h002A, "maker code");
      chk({15'h0, par_ok}, 16'h1, "maker parity");
      run(prom_host_pkg::CMD_ID, 1'b1, 16'h0001, 16'h0);
      chk(rdata, 16'h0083, "device code");
      $display("test ident done");
   endtask : t_ident
   // deep standby while idle, then a reset in mid-program
   task automatic t_standby();
      deep = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({15'h0, deep_o}, 16'h1, "deep standby");
      chk({14'h0, ce_n}, 16'h3, "deselected in standby");
      deep = 1'b0;
      cmd_valid = 1'b1;
      cmd = prom_host_pkg::CMD_PROG;
      dev = 1'b0;
      addr = 16'h0020;
      wdata = 16'h0F0F;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      repeat (50) @(posedge clk);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({11'h0, ce_n, oe_n, wp_n, vpp}, 16'h001E, "pins at rest");
      rst_n = 1'b1;
      run(prom_host_pkg::CMD_READ, 1'b0, 16'h0020, 16'h0);
      chk(rdata, 16'hFFFF, "aborted word untouched");
      $display("test standby done");
   endtask : t_standby
   ////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      cmd_valid = 1'b0;
      cmd = 2'h3;
      dev = 1'b0;
      addr = 16'h0;
      wdata = 16'h0;
      deep = 1'b0;
      errors = 0;
      n_compared = 0;
      pulses = 0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_program();
      t_stuck();
      t_freeze();
      t_ident();
      t_standby();
      print_verdict();
   end
endmodule : uv_prom_mode_select_tb
bind prom_host prom_host_asserts #(.ADDR_W(ADDR_W), .N_DEV(N_DEV), .PULSE_CYCLES(PULSE_CYCLES)) chk_u (
   .i_ref_clk, .i_rst_n, .i_ce, .o_busy, .o_ce_n, .o_deep_standby, .o_oe_n, .o_write_pulse_n,
   .o_program_supply_level, .o_id_entry_addr_line, .o_addr, .o_dq_oe);
`default_nettype wire
